// *** rtl/pgt_pkg.sv ***
package pgt_pkg;

    // ******************************************************
    // register offsets
    // ******************************************************
    localparam logic [7:0] PGT_OFS_FAULT_MASK2   = 8'hA3;
    localparam logic [7:0] PGT_OFS_OUT1_RAIL_SEL = 8'hA4;
    localparam logic [7:0] PGT_OFS_OUT1_PIN_SEL  = 8'hA5;
    localparam logic [7:0] PGT_OFS_OUT4_RAIL_SEL = 8'hA6;

    // ******************************************************
    // field positions
    // ******************************************************
    // second fault-mask group
    localparam int PGT_FM_LIN_A1   = 4;
    localparam int PGT_FM_TERM     = 3;
    localparam int PGT_FM_SW_B2    = 2;
    localparam int PGT_FM_SW_B1    = 1;
    localparam int PGT_FM_LIN_A3   = 0;
    localparam int PGT_FM_RO_BIT   = 7;
    // rail-select registers
    localparam int PGT_RS_LIN_A2   = 7;
    localparam int PGT_RS_RSVD     = 6;
    localparam int PGT_RS_SD_TOP   = 5;
    // pin-select register
    localparam int PGT_PS_CTRL5    = 7;
    localparam int PGT_PS_CTRL4    = 6;
    localparam int PGT_PS_CTRL2    = 5;
    localparam int PGT_PS_CTRL1    = 4;
    localparam int PGT_PS_TERM     = 3;
    localparam int PGT_PS_LIN_A3   = 0;

    // writable bits of the second fault-mask register
    localparam logic [7:0] PGT_FM_WR_MASK = 8'h7F;

    // ******************************************************
    // factory defaults of this variant
    // ******************************************************
    localparam logic [7:0] PGT_RST_FAULT_MASK2   = 8'h26;
    localparam logic [7:0] PGT_RST_OUT1_RAIL_SEL = 8'hFF;
    localparam logic [7:0] PGT_RST_OUT1_PIN_SEL  = 8'hFF;
    localparam logic [7:0] PGT_RST_OUT4_RAIL_SEL = 8'hC0;
    localparam logic       PGT_RST_OUT1_IS_GPO   = 1'b0;
    localparam logic       PGT_RST_OUT4_IS_GPO   = 1'b0;

    // ******************************************************
    // carriers
    // ******************************************************
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pgt_reg_req_t;

    typedef struct packed {
        logic [6:1] step_down_good;
        logic       lin_reg_a2_good;
        logic       lin_reg_a3_good;
        logic       termination_good;
        logic       ctrl_pin_1;
        logic       ctrl_pin_2;
        logic       ctrl_pin_4;
        logic       ctrl_pin_5;
    } pgt_rail_status_t;

    typedef struct packed {
        logic [7:0] fault_mask2;
        logic [7:0] out1_rail_sel;
        logic [7:0] out1_pin_sel;
        logic [7:0] out4_rail_sel;
        logic [7:0] rdata;
        logic       shutdown;
        logic       gp_out1;
        logic       gp_out4;
    } pgt_state_t;

endpackage

// *** rtl/pgt_regs.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - a masked rail fault in the second group never shuts down; an unmasked one does.
// - mask bits: lin A1 at 4, termination at 3, switch B2 at 2, switch B1 at 1, lin A3 at 0.
// - bits 7..5 of the fault mask are reserved; bit 7 is read only, 6..0 read/write.
// - a tree select bit of 0 includes that member, 1 excludes and ignores it.
// - output-one rail select: lin A2 at 7, reserved 6, step-down six..one at 5..0.
// - output-one pin select: pin 5 at 7, pin 4 at 6, pin 2 at 5, pin 1 at 4.
// - same register: termination good at 3, lin A3 good at 0, bits 2 and 1 reserved.
// - output-four rail select uses the output-one rail layout and encoding.
// - offsets A3h, A4h, A5h and A6h for the four registers.
// - every bit resets to its factory-programmed value.
// - a pin set up as general-purpose output follows its level bit, 0 low and 1 high.
module pgt_regs
    import pgt_pkg::*;
#(
    parameter logic [7:0] OTP_FAULT_MASK2   = PGT_RST_FAULT_MASK2,
    parameter logic [7:0] OTP_OUT1_RAIL_SEL = PGT_RST_OUT1_RAIL_SEL,
    parameter logic [7:0] OTP_OUT1_PIN_SEL  = PGT_RST_OUT1_PIN_SEL,
    parameter logic [7:0] OTP_OUT4_RAIL_SEL = PGT_RST_OUT4_RAIL_SEL,
    parameter logic       OTP_OUT1_IS_GPO   = PGT_RST_OUT1_IS_GPO,
    parameter logic       OTP_OUT4_IS_GPO   = PGT_RST_OUT4_IS_GPO
) (
    input  wire logic             i_clk,
    input  wire logic             i_sys_rst,
    input  wire pgt_reg_req_t     i_reg_req,
    input  wire pgt_rail_status_t i_rail_status,
    input  wire logic [4:0]       i_rail_fault,
    input  wire logic [7:0]       i_out4_pin_sel,
    input  wire logic             i_gp_output_one_level,
    input  wire logic             i_gp_output_four_level,
    output logic [7:0]            o_reg_rdata,
    output logic                  o_shutdown_req,
    output logic                  o_gp_output_one,
    output logic                  o_gp_output_four
);

    // ******************************************************
    // address decode
    // ******************************************************
    // used by both the write and the read path
    // the four offsets are distinct, so at most one select bit is ever set
    function automatic logic [3:0] pgt_decode(input logic [7:0] addr);
        logic [3:0] sel;
        sel    = 4'h0;
        sel[0] = (addr == PGT_OFS_FAULT_MASK2);
        sel[1] = (addr == PGT_OFS_OUT1_RAIL_SEL);
        sel[2] = (addr == PGT_OFS_OUT1_PIN_SEL);
        sel[3] = (addr == PGT_OFS_OUT4_RAIL_SEL);
        return sel;
    endfunction

    // ******************************************************
    // exclude vector of one tree
    // ******************************************************
    // rail select in the low byte, pin select in the high byte, as in the member
    // vector; reserved positions stay excluded whatever software writes there
    function automatic logic [15:0] pgt_exclude(input logic [7:0] rail,
                                                input logic [7:0] pin);
        logic [15:0] x;
        x                  = 16'hFFFF;
        x[PGT_RS_LIN_A2]   = rail[PGT_RS_LIN_A2];
        x[PGT_RS_SD_TOP:0] = rail[PGT_RS_SD_TOP:0];
        x[8+PGT_PS_CTRL5]  = pin[PGT_PS_CTRL5];
        x[8+PGT_PS_CTRL4]  = pin[PGT_PS_CTRL4];
        x[8+PGT_PS_CTRL2]  = pin[PGT_PS_CTRL2];
        x[8+PGT_PS_CTRL1]  = pin[PGT_PS_CTRL1];
        x[8+PGT_PS_TERM]   = pin[PGT_PS_TERM];
        x[8+PGT_PS_LIN_A3] = pin[PGT_PS_LIN_A3];
        return x;
    endfunction

    pgt_state_t st_q;
    pgt_state_t st_d;
    logic [3:0] wr_sel;
    logic [3:0] rd_sel;
    logic [15:0] out1_status;
    logic [15:0] out1_exclude;
    logic [15:0] out4_status;
    logic [15:0] out4_exclude;
    logic        out1_good;
    logic        out4_good;
    logic [4:0]  live_fault;

    assign wr_sel = i_reg_req.wr ? pgt_decode(i_reg_req.addr) : 4'h0;
    assign rd_sel = i_reg_req.rd ? pgt_decode(i_reg_req.addr) : 4'h0;

    // ******************************************************
    // tree member vectors, aligned to the select registers
    // ******************************************************
    // reserved positions carry a constant one so they never gate the tree
    always_comb begin
        out1_status                   = 16'hFFFF;
        out1_status[PGT_RS_LIN_A2]    = i_rail_status.lin_reg_a2_good;
        out1_status[PGT_RS_SD_TOP:0]  = i_rail_status.step_down_good;
        out1_status[8+PGT_PS_CTRL5]   = i_rail_status.ctrl_pin_5;
        out1_status[8+PGT_PS_CTRL4]   = i_rail_status.ctrl_pin_4;
        out1_status[8+PGT_PS_CTRL2]   = i_rail_status.ctrl_pin_2;
        out1_status[8+PGT_PS_CTRL1]   = i_rail_status.ctrl_pin_1;
        out1_status[8+PGT_PS_TERM]    = i_rail_status.termination_good;
        out1_status[8+PGT_PS_LIN_A3]  = i_rail_status.lin_reg_a3_good;
        // output four shares the layout of output one
        out4_status                   = out1_status;
    end

    // select registers act straight from the flops: a write shows next cycle
    assign out1_exclude = pgt_exclude(st_q.out1_rail_sel, st_q.out1_pin_sel);
    assign out4_exclude = pgt_exclude(st_q.out4_rail_sel, i_out4_pin_sel);

    // one tree per power-good pin; index 0 is output one, index 1 output four
    // a loop keeps both pins on a single tree description
    logic [15:0] tree_status  [2];
    logic [15:0] tree_exclude [2];
    logic [1:0]  tree_good;

    assign tree_status[0]  = out1_status;
    assign tree_status[1]  = out4_status;
    assign tree_exclude[0] = out1_exclude;
    assign tree_exclude[1] = out4_exclude;

    for (genvar t = 0; t < 2; t++) begin : g_tree
        pgt_tree #(
            .W (16)
        ) u_tree (
            .i_status  (tree_status[t]),
            .i_exclude (tree_exclude[t]),
            .o_good    (tree_good[t])
        );
    end

    assign out1_good = tree_good[0];
    assign out4_good = tree_good[1];

    // ******************************************************
    // fault qualification
    // ******************************************************
    // named taps of the mask; a 1 keeps that rail's fault from shutting down
    logic lin_reg_a1_fault_ignore;
    logic termination_reg_fault_ignore;
    logic load_switch_b2_fault_ignore;
    logic load_switch_b1_fault_ignore;
    logic lin_reg_a3_fault_ignore;

    assign lin_reg_a1_fault_ignore      = st_q.fault_mask2[PGT_FM_LIN_A1];
    assign termination_reg_fault_ignore = st_q.fault_mask2[PGT_FM_TERM];
    assign load_switch_b2_fault_ignore  = st_q.fault_mask2[PGT_FM_SW_B2];
    assign load_switch_b1_fault_ignore  = st_q.fault_mask2[PGT_FM_SW_B1];
    assign lin_reg_a3_fault_ignore      = st_q.fault_mask2[PGT_FM_LIN_A3];

    // masked faults are dropped here, before the shutdown flop
    // fault input bits follow the mask bit order
    assign live_fault = i_rail_fault & ~{lin_reg_a1_fault_ignore,
                                         termination_reg_fault_ignore,
                                         load_switch_b2_fault_ignore,
                                         load_switch_b1_fault_ignore,
                                         lin_reg_a3_fault_ignore};

    // ******************************************************
    // next state
    // ******************************************************
    always_comb begin
        st_d = st_q;
        // fault mask: bit 7 keeps its factory value, writes cannot reach it
        if (wr_sel[0]) begin
            st_d.fault_mask2 = (i_reg_req.wdata & PGT_FM_WR_MASK)
                             | (st_q.fault_mask2 & ~PGT_FM_WR_MASK);
        end
        if (wr_sel[1]) begin
            st_d.out1_rail_sel = i_reg_req.wdata;
        end
        if (wr_sel[2]) begin
            st_d.out1_pin_sel = i_reg_req.wdata;
        end
        if (wr_sel[3]) begin
            st_d.out4_rail_sel = i_reg_req.wdata;
        end
        // read data held until the next read; unmapped offsets read zero
        // a read and a write in one cycle return the value held before the write
        if (i_reg_req.rd) begin
            unique case (1'b1)
                rd_sel[0]: st_d.rdata = st_q.fault_mask2;
                rd_sel[1]: st_d.rdata = st_q.out1_rail_sel;
                rd_sel[2]: st_d.rdata = st_q.out1_pin_sel;
                rd_sel[3]: st_d.rdata = st_q.out4_rail_sel;
                default:   st_d.rdata = 8'h00;
            endcase
        end
        st_d.shutdown = |live_fault;
        // factory choice between level mode and power-good mode
        st_d.gp_out1 = OTP_OUT1_IS_GPO ? i_gp_output_one_level : out1_good;
        st_d.gp_out4 = OTP_OUT4_IS_GPO ? i_gp_output_four_level : out4_good;
    end

    // ******************************************************
    // state register
    // ******************************************************
    // synchronous reset loads the factory image
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            st_q.fault_mask2   <= OTP_FAULT_MASK2;
            st_q.out1_rail_sel <= OTP_OUT1_RAIL_SEL;
            st_q.out1_pin_sel  <= OTP_OUT1_PIN_SEL;
            st_q.out4_rail_sel <= OTP_OUT4_RAIL_SEL;
            st_q.rdata         <= 8'h00;
            st_q.shutdown      <= 1'b0;
            st_q.gp_out1       <= 1'b0;
            st_q.gp_out4       <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // ******************************************************
    // outputs
    // ******************************************************
    // every pin and the read port come straight from the state flops
    assign o_reg_rdata      = st_q.rdata;
    assign o_shutdown_req   = st_q.shutdown;
    assign o_gp_output_one  = st_q.gp_out1;
    assign o_gp_output_four = st_q.gp_out4;

endmodule

// *** rtl/pgt_tree.sv ***
`timescale 1ns/1ps
module pgt_tree
    import pgt_pkg::*;
#(
    parameter int W = 16
) (
    input  wire logic [W-1:0] i_status,
    input  wire logic [W-1:0] i_exclude,
    output logic              o_good
);
    // ******************************************************
    // and-tree over included members
    // ******************************************************
    // an excluded member is forced true so it cannot pull the tree low
    assign o_good = &(i_status | i_exclude);
endmodule

// *** tb/pgt_host.sv ***
`timescale 1ns/1ps
module pgt_host
    import pgt_pkg::*;
(
    input  wire logic   i_clk,
    output pgt_reg_req_t o_req
);
    // bus idle at start
    initial o_req = '{wr: 1'b0, rd: 1'b0, addr: 8'h00, wdata: 8'h00};
    // one access: raised after a falling edge, held through one rising edge
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk);
        o_req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge i_clk);
        // released lines invert so a stale value never passes for a live one
        o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
endmodule

// *** tb/pgt_regs_assertions.sv ***
`timescale 1ns/1ps
module pgt_regs_chk
    import pgt_pkg::*;
#(
    parameter logic OUT1_LEVEL_MODE = 1'b0,
    parameter logic OUT4_LEVEL_MODE = 1'b0
) (
    input wire logic             i_clk,
    input wire logic             i_sys_rst,
    input wire pgt_reg_req_t     i_reg_req,
    input wire pgt_rail_status_t i_rail_status,
    input wire logic [4:0]       i_rail_fault,
    input wire logic [7:0]       i_out4_pin_sel,
    input wire logic             i_gp_output_one_level,
    input wire logic             i_gp_output_four_level,
    input wire logic [7:0]       o_reg_rdata,
    input wire logic             o_shutdown_req,
    input wire logic             o_gp_output_one,
    input wire logic             o_gp_output_four
);
    // ****************
    // register shadow
    // ****************
    logic [7:0]  m_q [4];
    logic        map, sd_exp, g1_exp, g4_exp;
    logic [7:0]  m_rd;
    logic [15:0] sv;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    function automatic logic good(input logic [15:0] s, input logic [15:0] x);
        return &(s | x);
    endfunction
    // reserved tree positions tied high so they never pull the result down
    assign sv = {i_rail_status.lin_reg_a2_good, 1'h1, i_rail_status.step_down_good,
                 i_rail_status.ctrl_pin_5, i_rail_status.ctrl_pin_4, i_rail_status.ctrl_pin_2,
                 i_rail_status.ctrl_pin_1, i_rail_status.termination_good, 2'h3,
                 i_rail_status.lin_reg_a3_good};
    assign map = i_reg_req.addr >= 8'hA3 && i_reg_req.addr <= 8'hA6;
    assign m_rd = m_q[i_reg_req.addr[1:0]];
    assign sd_exp = |(i_rail_fault & ~m_q[3][4:0]);
    // a pin in level mode follows its level bit, otherwise its tree
    assign g1_exp = OUT1_LEVEL_MODE ? i_gp_output_one_level
                                    : good(sv, {m_q[0], m_q[1]});
    assign g4_exp = OUT4_LEVEL_MODE ? i_gp_output_four_level
                                    : good(sv, {m_q[2], i_out4_pin_sel});
    // low two offset bits are unique across the four registers
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            m_q <= '{PGT_RST_OUT1_RAIL_SEL, PGT_RST_OUT1_PIN_SEL, PGT_RST_OUT4_RAIL_SEL,
                     PGT_RST_FAULT_MASK2};
        end else if (i_reg_req.wr && map) begin
            m_q[i_reg_req.addr[1:0]] <= (i_reg_req.addr[1:0] == 2'h3)
                ? (i_reg_req.wdata & PGT_FM_WR_MASK) | (m_q[3] & ~PGT_FM_WR_MASK)
                : i_reg_req.wdata;
        end
    end
    property p_rd; map && i_reg_req.rd |=> o_reg_rdata == $past(m_rd); endproperty
    a_rd: assert property (p_rd) else $error("read data wrong");
    property p_unm; !map && i_reg_req.rd |=> o_reg_rdata == 8'h00; endproperty
    a_unm: assert property (p_unm) else $error("unmapped read not zero");
    property p_hold; !i_reg_req.rd |=> $stable(o_reg_rdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_rst; $past(i_sys_rst) |-> !o_shutdown_req && o_reg_rdata == 8'h00; endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
    property p_sd; !$past(i_sys_rst) |-> o_shutdown_req == $past(sd_exp); endproperty
    a_sd: assert property (p_sd) else $error("shutdown wrong");
    property p_sdm; !sd_exp ##1 !sd_exp |-> !o_shutdown_req; endproperty
    a_sdm: assert property (p_sdm) else $error("masked fault shut down");
    property p_g1; !$past(i_sys_rst) |-> o_gp_output_one == $past(g1_exp); endproperty
    a_g1: assert property (p_g1) else $error("output one tree wrong");
    property p_g4; !$past(i_sys_rst) |-> o_gp_output_four == $past(g4_exp); endproperty
    a_g4: assert property (p_g4) else $error("output four tree wrong");
endmodule
bind pgt_regs pgt_regs_chk #(
    .OUT1_LEVEL_MODE (OTP_OUT1_IS_GPO),
    .OUT4_LEVEL_MODE (OTP_OUT4_IS_GPO)
) chk (.i_clk, .i_sys_rst, .i_reg_req, .i_rail_status, .i_rail_fault,
    .i_out4_pin_sel, .i_gp_output_one_level, .i_gp_output_four_level, .o_reg_rdata,
    .o_shutdown_req, .o_gp_output_one, .o_gp_output_four);

// *** tb/tb_power_good_tree_fault_mask_regs.sv ***
`timescale 1ns/1ps
module tb_power_good_tree_fault_mask_regs
    import pgt_pkg::*;
;
    // ****************
    // bench
    // ****************
    logic             i_clk = 1'b0;
    logic             i_sys_rst = 1'b1;
    pgt_reg_req_t     req;
    pgt_rail_status_t st;
    logic [15:0]      sv = 16'hFFFF;
    logic [15:0]      x;
    logic [4:0]       flt = 5'h00;
    logic [7:0]       ps4 = 8'h00;
    logic [7:0]       rdata;
    logic             sd, g1, g4, q1, q4;
    logic             lvl1 = 1'b0, lvl4 = 1'b1;
    int               errors = 0, cmp_count = 0, cyc = 0;
    logic [7:0]       rv [6] = '{8'h00, PGT_RST_FAULT_MASK2, PGT_RST_OUT1_RAIL_SEL,
                                 PGT_RST_OUT1_PIN_SEL, PGT_RST_OUT4_RAIL_SEL, 8'h00};
    assign st = {sv[13:8], sv[15], sv[0], sv[3], sv[4], sv[5], sv[6], sv[7]};
    pgt_regs dut (.i_clk, .i_sys_rst, .i_reg_req(req), .i_rail_status(st), .i_rail_fault(flt),
        .i_out4_pin_sel(ps4), .i_gp_output_one_level(lvl1), .i_gp_output_four_level(lvl4),
        .o_reg_rdata(rdata), .o_shutdown_req(sd), .o_gp_output_one(g1), .o_gp_output_four(g4));
    // same bank with both pins set up as plain level outputs
    pgt_regs #(.OTP_OUT1_IS_GPO(1'b1), .OTP_OUT4_IS_GPO(1'b1)) dut_lvl (.i_clk, .i_sys_rst,
        .i_reg_req(req), .i_rail_status(st), .i_rail_fault(flt), .i_out4_pin_sel(ps4),
        .i_gp_output_one_level(lvl1), .i_gp_output_four_level(lvl4), .o_reg_rdata(),
        .o_shutdown_req(), .o_gp_output_one(q1), .o_gp_output_four(q4));
    pgt_host host (.i_clk, .o_req(req));
    always #20 i_clk = ~i_clk;
    task automatic chk(input logic [7:0] got, input logic [7:0] want);
        cmp_count++;
        if (got !== want) begin
            errors++;
            $display("BAD t=%0t got %h exp %h", $time, got, want);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] want);
        host.acc(1'b0, a, 8'h00);
        chk(rdata, want);
    endtask
    // outputs settle two edges after a select write
    task automatic w2();
        repeat (2) @(negedge i_clk);
    endtask
    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // hang guard; the sequence needs well under a thousand cycles
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            end_sim();
        end
    end
    initial begin
        repeat (8) @(negedge i_clk);
        i_sys_rst = 1'b0;
        for (int i = 0; i < 6; i++) rd(8'hA2 + 8'(i), rv[i]);
        $display("reset values done");
        for (int i = 0; i < 6; i++) host.acc(1'b1, 8'hA2 + 8'(i), 8'hFF);
        for (int i = 1; i < 5; i++) rd(8'hA2 + 8'(i), (i == 1) ? 8'h7F : 8'hFF);
        rd(8'hA7, 8'h00);
        $display("access done");
        // unmask one fault at a time, then raise all the others
        for (int i = 0; i < 5; i++) begin
            host.acc(1'b1, 8'hA3, ~(8'h01 << i));
            flt = 5'h01 << i;
            w2();
            chk({7'h00, sd}, 8'h01);
            flt = ~(5'h01 << i);
            w2();
            chk({7'h00, sd}, 8'h00);
        end
        $display("fault mask done");
        for (int i = 0; i < 3; i++) host.acc(1'b1, 8'hA4 + 8'(i), 8'h00);
        ps4 = 8'h00;
        // drop one member, check, then exclude that member alone
        for (int i = 0; i < 16; i++) begin
            sv = ~(16'h0001 << i);
            x = 16'h0001 << i;
            w2();
            chk({6'h00, g1, g4}, (i == 14 || i == 2 || i == 1) ? 8'h03 : 8'h00);
            host.acc(1'b1, 8'hA4, x[15:8]);
            host.acc(1'b1, 8'hA5, x[7:0]);
            host.acc(1'b1, 8'hA6, x[15:8]);
            ps4 = x[7:0];
            w2();
            chk({6'h00, g1, g4}, 8'h03);
        end
        $display("tree done");
        // level mode pins follow their level bits; tree pins ignore them
        for (int i = 0; i < 4; i++) begin
            lvl1 = i[0];
            lvl4 = i[1];
            w2();
            chk({6'h00, q1, q4}, {6'h00, i[0], i[1]});
            chk({6'h00, g1, g4}, 8'h03);
        end
        $display("level mode done");
        i_sys_rst = 1'b1;
        repeat (8) @(negedge i_clk);
        i_sys_rst = 1'b0;
        rd(8'hA6, PGT_RST_OUT4_RAIL_SEL);
        $display("second reset done");
        end_sim();
    end
endmodule
